// >>> logic/fpkc_defs.svh
`ifndef FPKC_DEFS_SVH
`define FPKC_DEFS_SVH

// System clock rate
`define FPKC_CLK_HZ 25000000
// Cycles in one millisecond
`define FPKC_MS_CYCLES (`FPKC_CLK_HZ / 1000)

// Timing figures, in their own units
`define FPKC_PWR_HOLD_S 2
`define FPKC_FORCE_OFF_S 10
`define FPKC_PWR_HOLD_MS (`FPKC_PWR_HOLD_S * 1000)
`define FPKC_FORCE_OFF_MS (`FPKC_FORCE_OFF_S * 1000)
`define FPKC_SPLASH_MS 1000
`define FPKC_BLINK_MS 250
`define FPKC_DEBOUNCE_MS 20

// Key vector layout
`define FPKC_NKEYS 11
`define FPKC_K_AXIS 0
`define FPKC_K_RECALL 1
`define FPKC_K_PEAKCLR 2
`define FPKC_K_START 3
`define FPKC_K_PAUSE 4
`define FPKC_K_POWER 5
`define FPKC_K_MENU 6
`define FPKC_K_LIGHT 7
`define FPKC_K_DISPLAY 8
`define FPKC_K_LEFT 9
`define FPKC_K_RIGHT 10

// Register byte offsets
`define FPKC_REG_CTRL 8'h00
`define FPKC_REG_BL_TIME 8'h04
`define FPKC_REG_STATUS 8'h08

// Control fields
`define FPKC_CTRL_BL_AUTO 0
`define FPKC_CTRL_STORE_LO 1
`define FPKC_CTRL_STORE_HI 2
`define FPKC_CTRL_CALIB 3

// Reset values
`define FPKC_CTRL_RST 3'h0
`define FPKC_BL_TIME_RST 16'h2710

`endif

// >>> logic/fpkc_pkg.sv
package fpkc_pkg;

   // Gray order along off, boot, splash, on
   typedef enum logic [1:0] {
      FPKC_OFF = 2'h0,
      FPKC_BOOT = 2'h1,
      FPKC_SPLASH = 2'h3,
      FPKC_ON = 2'h2
   } fpkc_pwr_t;

   typedef enum logic [2:0] {
      FPKC_MEAS = 3'h0,
      FPKC_MAXH = 3'h1,
      FPKC_PROC = 3'h3,
      FPKC_TLVL = 3'h2,
      FPKC_MENU = 3'h6,
      FPKC_RECALL = 3'h7,
      FPKC_CALIB = 3'h5
   } fpkc_scr_t;

   typedef enum logic [1:0] {
      FPKC_AX_X = 2'h0,
      FPKC_AX_Y = 2'h1,
      FPKC_AX_Z = 2'h3,
      FPKC_AX_XYZ = 2'h2
   } fpkc_axis_t;

   typedef enum logic [1:0] {
      FPKC_ST_MANUAL = 2'h0,
      FPKC_ST_AUTO = 2'h1,
      FPKC_ST_TIMER = 2'h2
   } fpkc_store_t;

endpackage

// >>> logic/fpkc_tick.sv
`timescale 1ns/1ps
`include "fpkc_defs.svh"

module fpkc_tick #(
   parameter logic [14:0] MS_CYC = 15'(`FPKC_MS_CYCLES)
) (
   input wire logic sys_clk,
   input wire logic nrst,
   output logic ms_tick,
   output logic blink
);
   localparam logic [7:0] BLINK_LAST = 8'(`FPKC_BLINK_MS - 1);
   logic [14:0] div_q;
   logic [7:0] bl_q;

   // Millisecond enable and lamp blink phase
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         div_q <= 15'h0000;
         bl_q <= 8'h00;
         ms_tick <= 1'b0;
         blink <= 1'b0;
      end else begin
         ms_tick <= (div_q == MS_CYC - 15'h0001);
         div_q <= (div_q == MS_CYC - 15'h0001) ? 15'h0000 : div_q + 15'h0001;
         if (ms_tick) begin
            bl_q <= (bl_q == BLINK_LAST) ? 8'h00 : bl_q + 8'h01;
            if (bl_q == BLINK_LAST) begin
               blink <= ~blink;
            end
         end
      end
   end
endmodule

// >>> logic/fpkc_debounce.sv
`timescale 1ns/1ps
`include "fpkc_defs.svh"

module fpkc_debounce (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ms_tick,
   input wire logic [`FPKC_NKEYS-1:0] key_raw,
   output logic [`FPKC_NKEYS-1:0] key_lvl,
   output logic [`FPKC_NKEYS-1:0] key_press
);
   localparam logic [4:0] DB_LAST = 5'(`FPKC_DEBOUNCE_MS - 1);
   logic [`FPKC_NKEYS-1:0] m_q;
   logic [`FPKC_NKEYS-1:0] s_q;
   logic [4:0] cnt_q [`FPKC_NKEYS];

   // Two-stage sync, then a level must hold for the whole window
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         m_q <= '0;
         s_q <= '0;
         key_lvl <= '0;
         key_press <= '0;
         for (int i = 0; i < `FPKC_NKEYS; i++) begin
            cnt_q[i] <= 5'h00;
         end
      end else begin
         m_q <= key_raw;
         s_q <= m_q;
         key_press <= '0;
         for (int i = 0; i < `FPKC_NKEYS; i++) begin
            if (ms_tick) begin
               if (s_q[i] == key_lvl[i]) begin
                  cnt_q[i] <= 5'h00;
               end else if (cnt_q[i] == DB_LAST) begin
                  cnt_q[i] <= 5'h00;
                  key_lvl[i] <= s_q[i];
                  key_press[i] <= s_q[i];
               end else begin
                  cnt_q[i] <= cnt_q[i] + 5'h01;
               end
            end
         end
      end
   end
endmodule

// >>> logic/fpkc_top.sv
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "fpkc_defs.svh"
module fpkc_top #(
   parameter logic [14:0] MS_CYC = 15'(`FPKC_MS_CYCLES),
   parameter logic [15:0] PWR_MS = 16'(`FPKC_PWR_HOLD_MS),
   parameter logic [15:0] FORCE_MS = 16'(`FPKC_FORCE_OFF_MS),
   parameter logic [15:0] SPLASH_MS = 16'(`FPKC_SPLASH_MS)
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [`FPKC_NKEYS-1:0] key_raw,
   input wire logic supply_present,
   input wire logic supply_trig_sw,
   input wire logic adapter_only,
   input wire logic standby,
   input wire logic boot_done,
   input wire logic auto_close_req,
   input wire logic auto_shutdown_req,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic power_on_q,
   output logic splash_q,
   output fpkc_pkg::fpkc_scr_t screen_q,
   output fpkc_pkg::fpkc_axis_t axis_q,
   output logic paused_q,
   output logic running_q,
   output logic backlight_q,
   output logic lock_sym_q,
   output logic lock_ind_q,
   output logic peak_clear_q,
   output logic commit_q,
   output logic settings_view_q,
   output logic lamp_red_q,
   output logic lamp_blue_q,
   output logic auto_close_q,
   output logic auto_shutdown_q
);
   import fpkc_pkg::*;

   // Byte-lane merge for register writes
   function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic fpkc_axis_t next_axis(input fpkc_axis_t a);
      case (a)
         FPKC_AX_X: next_axis = FPKC_AX_Y;
         FPKC_AX_Y: next_axis = FPKC_AX_Z;
         FPKC_AX_Z: next_axis = FPKC_AX_XYZ;
         default: next_axis = FPKC_AX_X;
      endcase
   endfunction

   function automatic fpkc_scr_t next_view(input fpkc_scr_t s);
      case (s)
         FPKC_MEAS: next_view = FPKC_MAXH;
         FPKC_MAXH: next_view = FPKC_PROC;
         FPKC_PROC: next_view = FPKC_TLVL;
         default: next_view = FPKC_MEAS;
      endcase
   endfunction

   logic ms_tick;
   logic blink;
   logic [`FPKC_NKEYS-1:0] key_lvl;
   logic [`FPKC_NKEYS-1:0] key_press;
   logic [2:0] pin_m_q;
   logic [2:0] pin_s_q;
   logic sup_prev_q;
   fpkc_pwr_t pwr_q;
   fpkc_pwr_t pwr_d;
   fpkc_scr_t scr_d;
   logic locked_q;
   logic [15:0] hold_q;
   logic [15:0] splash_cnt_q;
   logic [15:0] bl_ms_q;
   logic [2:0] ctrl_q;
   logic [15:0] bl_time_q;
   logic calib_go_q;

   fpkc_tick #(
      .MS_CYC(MS_CYC)
   ) u_tick (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .ms_tick(ms_tick),
      .blink(blink)
   );

   fpkc_debounce u_deb (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .ms_tick(ms_tick),
      .key_raw(key_raw),
      .key_lvl(key_lvl),
      .key_press(key_press)
   );

   // Pin synchronisers: supply, mode switch, adapter-only
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pin_m_q <= 3'h0;
         pin_s_q <= 3'h0;
         sup_prev_q <= 1'b0;
      end else begin
         pin_m_q <= {adapter_only, supply_trig_sw, supply_present};
         pin_s_q <= pin_m_q;
         sup_prev_q <= pin_s_q[0];
      end
   end

   wire sup_s = pin_s_q[0];
   wire trig_s = pin_s_q[1];
   wire adp_s = pin_s_q[2];
   wire bl_auto = ctrl_q[`FPKC_CTRL_BL_AUTO];
   wire [1:0] store_mode = ctrl_q[`FPKC_CTRL_STORE_HI:`FPKC_CTRL_STORE_LO];

   // Key event decode; actions only while fully on
   wire on = (pwr_q == FPKC_ON);
   wire is_view = (screen_q == FPKC_MEAS) | (screen_q == FPKC_MAXH) |
                  (screen_q == FPKC_PROC) | (screen_q == FPKC_TLVL);
   wire scr_busy = (screen_q == FPKC_MENU) | (screen_q == FPKC_CALIB);
   wire combo = (key_press[`FPKC_K_LEFT] & key_lvl[`FPKC_K_RIGHT]) |
                (key_press[`FPKC_K_RIGHT] & key_lvl[`FPKC_K_LEFT]);
   wire lock_tog = on & combo & (locked_q | ~scr_busy);
   wire normal = on & ~combo & ~locked_q;
   wire [`FPKC_NKEYS-1:0] not_light = ~(`FPKC_NKEYS'(1) << `FPKC_K_LIGHT);
   wire lk_hit = on & ~combo & locked_q & |(key_press & not_light);
   wire light_tog = on & key_press[`FPKC_K_LIGHT];
   wire pause_ok = (store_mode != FPKC_ST_AUTO) & (store_mode != FPKC_ST_TIMER);
   wire pause_act = normal & key_press[`FPKC_K_PAUSE] & pause_ok;
   wire manual = pause_ok; // Code 3 behaves as manual store

   // Power-key hold timing; each threshold fires once per hold
   wire hold_tick = ms_tick & key_lvl[`FPKC_K_POWER];
   wire hit_norm = hold_tick & (hold_q == PWR_MS - 16'h0001);
   wire hit_force = hold_tick & (hold_q == FORCE_MS - 16'h0001);
   wire sup_rise = sup_s & ~sup_prev_q;
   wire boot_req = (pwr_q == FPKC_OFF) &
                   ((~trig_s & hit_norm) | (trig_s & sup_rise));
   wire off_norm = on & hit_norm & ~locked_q & ~trig_s;
   wire off_force = on & hit_force & locked_q;
   wire splash_end = ms_tick & (splash_cnt_q == SPLASH_MS - 16'h0001);
   wire bl_expire = bl_auto & backlight_q & ms_tick & (bl_ms_q >= bl_time_q);

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         hold_q <= 16'h0000;
      end else if (!key_lvl[`FPKC_K_POWER]) begin
         hold_q <= 16'h0000;
      end else if (ms_tick && hold_q != FORCE_MS) begin
         hold_q <= hold_q + 16'h0001;
      end
   end

   // Power sequence: off, boot blink, splash, on
   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         FPKC_OFF: begin
            if (boot_req) begin
               pwr_d = FPKC_BOOT;
            end
         end
         FPKC_BOOT: begin
            if (boot_done) begin
               pwr_d = FPKC_SPLASH;
            end
         end
         FPKC_SPLASH: begin
            if (splash_end) begin
               pwr_d = FPKC_ON;
            end
         end
         FPKC_ON: begin
            if (off_norm || off_force) begin
               pwr_d = FPKC_OFF;
            end
         end
         default: pwr_d = FPKC_OFF;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pwr_q <= FPKC_OFF;
         splash_cnt_q <= 16'h0000;
      end else begin
         pwr_q <= pwr_d;
         if (pwr_q != FPKC_SPLASH) begin
            splash_cnt_q <= 16'h0000;
         end else if (ms_tick) begin
            splash_cnt_q <= splash_cnt_q + 16'h0001;
         end
      end
   end

   // Screen selection; anything but on returns to measurement
   always_comb begin
      scr_d = screen_q;
      if (!on) begin
         scr_d = FPKC_MEAS;
      end else if (normal) begin
         if (is_view && key_press[`FPKC_K_DISPLAY]) begin
            scr_d = next_view(screen_q);
         end else if (screen_q == FPKC_MEAS && key_press[`FPKC_K_MENU]) begin
            scr_d = FPKC_MENU;
         end else if (screen_q == FPKC_MEAS && key_press[`FPKC_K_RECALL]) begin
            scr_d = FPKC_RECALL;
         end else if (screen_q == FPKC_MEAS && calib_go_q) begin
            scr_d = FPKC_CALIB;
         end else if (!is_view && key_press[`FPKC_K_START]) begin
            scr_d = FPKC_MEAS;
         end
      end
   end

   // Operator state; cleared whenever the unit is not on
   always_ff @(posedge sys_clk) begin
      if (!nrst || !on) begin
         screen_q <= FPKC_MEAS;
         axis_q <= FPKC_AX_X;
         locked_q <= 1'b0;
         paused_q <= 1'b0;
         running_q <= 1'b0;
         backlight_q <= 1'b0;
      end else begin
         screen_q <= scr_d;
         if (lock_tog) begin
            locked_q <= ~locked_q;
         end
         if (normal && key_press[`FPKC_K_AXIS]) begin
            axis_q <= next_axis(axis_q);
         end
         if (pause_act) begin
            paused_q <= ~paused_q;
         end
         if (normal && is_view && key_press[`FPKC_K_START]) begin
            running_q <= ~running_q;
         end
         if (light_tog) begin
            backlight_q <= ~backlight_q;
         end else if (bl_expire) begin
            backlight_q <= 1'b0;
         end
      end
   end

   // Backlight on-time, restarted at each switch-on
   always_ff @(posedge sys_clk) begin
      if (!nrst || !backlight_q) begin
         bl_ms_q <= 16'h0000;
      end else if (ms_tick && bl_ms_q != 16'hFFFF) begin
         bl_ms_q <= bl_ms_q + 16'h0001;
      end
   end

   // Pulses, lamps and gated supply requests
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         power_on_q <= 1'b0;
         splash_q <= 1'b0;
         lock_sym_q <= 1'b0;
         lock_ind_q <= 1'b0;
         peak_clear_q <= 1'b0;
         commit_q <= 1'b0;
         settings_view_q <= 1'b0;
         lamp_red_q <= 1'b0;
         lamp_blue_q <= 1'b0;
         auto_close_q <= 1'b0;
         auto_shutdown_q <= 1'b0;
      end else begin
         power_on_q <= (pwr_q != FPKC_OFF);
         splash_q <= (pwr_q == FPKC_SPLASH);
         lock_sym_q <= locked_q;
         lock_ind_q <= lk_hit;
         peak_clear_q <= normal & key_press[`FPKC_K_PEAKCLR];
         commit_q <= normal & key_press[`FPKC_K_MENU] & (screen_q == FPKC_MENU);
         settings_view_q <= light_tog & standby;
         lamp_red_q <= (pwr_q == FPKC_BOOT) & blink;
         lamp_blue_q <= ((pwr_q == FPKC_BOOT) & ~blink) |
                        (on & paused_q & manual & blink);
         auto_close_q <= auto_close_req & ~adp_s;
         auto_shutdown_q <= auto_shutdown_req & ~adp_s;
      end
   end

   // Wishbone slave: ack one cycle after strobe, zero for holes
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i;
   wire hit_ctrl = (wb_adr_i == `FPKC_REG_CTRL);
   wire hit_blt = (wb_adr_i == `FPKC_REG_BL_TIME);
   wire hit_stat = (wb_adr_i == `FPKC_REG_STATUS);
   wire [31:0] ctrl_w = wb_merge({29'h0, ctrl_q}, wb_dat_i, wb_sel_i);
   wire [31:0] blt_w = wb_merge({16'h0, bl_time_q}, wb_dat_i, wb_sel_i);
   wire [31:0] stat_v = {21'h0, backlight_q, locked_q, running_q, paused_q,
                         axis_q, screen_q, pwr_q};
   wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl_q} :
                        hit_blt ? {16'h0, bl_time_q} :
                        hit_stat ? stat_v : 32'h0;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl_q <= `FPKC_CTRL_RST;
         bl_time_q <= `FPKC_BL_TIME_RST;
         calib_go_q <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
         calib_go_q <= wb_wr & hit_ctrl & wb_sel_i[0] & wb_dat_i[`FPKC_CTRL_CALIB];
         if (wb_req) begin
            wb_dat_o <= rd_mux;
         end
         if (wb_wr && hit_ctrl) begin
            ctrl_q <= ctrl_w[2:0];
         end
         if (wb_wr && hit_blt) begin
            bl_time_q <= blt_w[15:0];
         end
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   chk_axis_wrap: assert property (
      (normal && key_press[`FPKC_K_AXIS] && axis_q == FPKC_AX_XYZ)
      |=> axis_q == FPKC_AX_X)
      else $error("axis did not wrap to X");

   chk_view_step: assert property (
      (normal && key_press[`FPKC_K_DISPLAY] && screen_q == FPKC_TLVL)
      |=> screen_q == FPKC_MEAS)
      else $error("view did not return to measurement");

   chk_pause_ignored: assert property (
      (on && key_press[`FPKC_K_PAUSE] && !pause_ok) |=> $stable(paused_q))
      else $error("pause acted in auto store mode");

   chk_pause_lamp: assert property (
      (on && paused_q && manual) [*2] |-> !lamp_red_q && (lamp_blue_q == $past(blink)))
      else $error("pause lamp not blinking blue");

   chk_lock_blocks: assert property (
      (on && locked_q && !combo && |(key_press & not_light))
      |=> lock_ind_q && $stable(screen_q) && $stable(axis_q))
      else $error("locked key acted or gave no indication");

   chk_menu_nolock: assert property (
      (on && !locked_q && scr_busy && combo) |=> !locked_q)
      else $error("lock entered on menu screen");

   chk_power_hold: assert property (
      (pwr_q == FPKC_ON && pwr_d == FPKC_OFF && !locked_q) |-> hold_q == PWR_MS - 16'h0001)
      else $error("power-down without two-second hold");

   chk_lock_off: assert property (
      (pwr_q == FPKC_ON && locked_q && hold_q < FORCE_MS - 16'h0001) |=> pwr_q == FPKC_ON)
      else $error("locked unit powered down early");

   chk_adapter_gate: assert property (
      adp_s |=> !auto_close_q && !auto_shutdown_q)
      else $error("auto close or shutdown on adapter only");

   chk_start_lamp: assert property (
      (pwr_q == FPKC_BOOT) [*2] |-> lamp_red_q != lamp_blue_q)
      else $error("start-up lamp not alternating");
endmodule

// >>> dv/fpkc_keypad.sv
`timescale 1ns/1ps
`include "fpkc_defs.svh"
// Operator at the keypad; contacts chatter on make and on break
module fpkc_keypad (
   input wire logic sys_clk,
   output logic [`FPKC_NKEYS-1:0] key_raw
);
   initial begin
      key_raw = '0;
   end
   // Three flips, one per edge, land on the opposite level
   task automatic flip(input int i);
      repeat (3) begin
         @(posedge sys_clk);
         key_raw[i] <= ~key_raw[i];
      end
   endtask
endmodule

// >>> dv/tb_front_panel_key_controller.sv
`timescale 1ns/1ps
`include "fpkc_defs.svh"
module tb_front_panel_key_controller;
   import fpkc_pkg::*;
   typedef struct {int k; fpkc_axis_t ax; fpkc_scr_t sc; logic [2:0] f;} fpkc_row_t;
   logic sys_clk = 0, nrst = 0, supply_present = 0, supply_trig_sw = 0, adapter_only = 0;
   logic standby = 0, boot_done = 0, auto_close_req = 0, auto_shutdown_req = 0;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
   logic wb_ack_o, power_on_q, splash_q, paused_q, running_q, backlight_q, lock_sym_q;
   logic lock_ind_q, peak_clear_q, commit_q, settings_view_q, lamp_red_q, lamp_blue_q;
   logic auto_close_q, auto_shutdown_q;
   logic [`FPKC_NKEYS-1:0] key_raw;
   fpkc_scr_t screen_q;
   fpkc_axis_t axis_q;
   int errors = 0, tests_run = 0, cycles = 0, n, c, s;
   int n_commit = 0, n_lock = 0, n_peak = 0, n_view = 0, n_close = 0, n_shut = 0;
   fpkc_row_t rows [14];
   always #20 sys_clk = ~sys_clk;
   fpkc_keypad kp (.sys_clk(sys_clk), .key_raw(key_raw));
   // Short counts so a power hold outlasts the debounce; splash keeps its own length
   fpkc_top #(.MS_CYC(15'd10), .PWR_MS(16'd40), .FORCE_MS(16'd80)) dut (
      .sys_clk(sys_clk), .nrst(nrst), .key_raw(key_raw), .supply_present(supply_present),
      .supply_trig_sw(supply_trig_sw), .adapter_only(adapter_only), .standby(standby),
      .boot_done(boot_done), .auto_close_req(auto_close_req),
      .auto_shutdown_req(auto_shutdown_req), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .power_on_q(power_on_q),
      .splash_q(splash_q), .screen_q(screen_q), .axis_q(axis_q), .paused_q(paused_q),
      .running_q(running_q), .backlight_q(backlight_q), .lock_sym_q(lock_sym_q),
      .lock_ind_q(lock_ind_q), .peak_clear_q(peak_clear_q), .commit_q(commit_q),
      .settings_view_q(settings_view_q), .lamp_red_q(lamp_red_q),
      .lamp_blue_q(lamp_blue_q), .auto_close_q(auto_close_q),
      .auto_shutdown_q(auto_shutdown_q));
   // Pulse outputs last one cycle, so count them on every edge
   always @(posedge sys_clk) begin
      n_commit += (commit_q === 1'b1);
      n_lock += (lock_ind_q === 1'b1);
      n_peak += (peak_clear_q === 1'b1);
      n_view += (settings_view_q === 1'b1);
      n_close += (auto_close_q === 1'b1);
      n_shut += (auto_shutdown_q === 1'b1);
      cycles++;
      if (cycles == 90000) begin
         errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Request held until ack is seen high at a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] sel = 4'hF);
      int k;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= sel;
      wb_dat_i <= d;
      k = 0;
      // Ack and read data are both taken at the rising edge
      do begin
         @(posedge sys_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      if (wb_ack_o !== 1'b1) chk(0, 1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic tap(input int k, input int ms);
      kp.flip(k);
      repeat (ms * 10) @(posedge sys_clk);
      kp.flip(k);
      repeat (250) @(posedge sys_clk);
   endtask
   task automatic combo();
      kp.flip(9);
      repeat (250) @(posedge sys_clk);
      tap(10, 25);
      kp.flip(9);
      repeat (250) @(posedge sys_clk);
   endtask
   // Main sequence: power up, row table, then awkward cases
   initial begin
      rows = '{'{0, FPKC_AX_Y, FPKC_MEAS, 3'h0}, '{0, FPKC_AX_Z, FPKC_MEAS, 3'h0},
         '{0, FPKC_AX_XYZ, FPKC_MEAS, 3'h0}, '{0, FPKC_AX_X, FPKC_MEAS, 3'h0},
         '{8, FPKC_AX_X, FPKC_MAXH, 3'h0}, '{8, FPKC_AX_X, FPKC_PROC, 3'h0},
         '{8, FPKC_AX_X, FPKC_TLVL, 3'h0}, '{8, FPKC_AX_X, FPKC_MEAS, 3'h0},
         '{4, FPKC_AX_X, FPKC_MEAS, 3'h4}, '{4, FPKC_AX_X, FPKC_MEAS, 3'h0},
         '{3, FPKC_AX_X, FPKC_MEAS, 3'h2}, '{3, FPKC_AX_X, FPKC_MEAS, 3'h0},
         '{7, FPKC_AX_X, FPKC_MEAS, 3'h1}, '{7, FPKC_AX_X, FPKC_MEAS, 3'h0}};
      repeat (3) @(posedge sys_clk);
      nrst <= 1;
      @(posedge sys_clk);
      chk({power_on_q, screen_q, axis_q}, {1'b0, FPKC_MEAS, FPKC_AX_X});
      tap(5, 25);
      chk(power_on_q, 0);
      tap(5, 50);
      chk(power_on_q, 1);
      for (n = 0; n < 3000 && lamp_red_q !== 1'b1; n++) @(posedge sys_clk);
      for (n = 0; n < 3000 && lamp_blue_q !== 1'b1; n++) @(posedge sys_clk);
      chk({lamp_red_q, lamp_blue_q}, 2'b01);
      boot_done <= 1;
      for (n = 0; n < 100 && splash_q !== 1'b1; n++) @(posedge sys_clk);
      chk(splash_q, 1);
      for (n = 0; n < 11000 && splash_q !== 1'b0; n++) @(posedge sys_clk);
      chk({splash_q, screen_q}, {1'b0, FPKC_MEAS});
      foreach (rows[i]) begin
         tap(rows[i].k, 25);
         chk(axis_q, rows[i].ax);
         chk(screen_q, rows[i].sc);
         chk({paused_q, running_q, backlight_q}, rows[i].f);
      end
      tap(4, 25);
      for (n = 0; n < 3000 && lamp_blue_q !== 1'b1; n++) @(posedge sys_clk);
      chk(lamp_blue_q, 1);
      tap(4, 25);
      for (c = 1; c <= 2; c++) begin
         wb(1, `FPKC_REG_CTRL, c << 1);
         tap(4, 25);
         chk(paused_q, 0);
      end
      wb(1, `FPKC_REG_CTRL, 0);
      wb(0, `FPKC_REG_BL_TIME, 0);
      chk(rd, 32'h2710);
      wb(0, 8'h40, 0);
      chk(rd, 0);
      wb(1, `FPKC_REG_BL_TIME, 32'hFFFF3300, 4'h2);
      wb(0, `FPKC_REG_BL_TIME, 0);
      chk(rd, 32'h3310);
      wb(1, `FPKC_REG_BL_TIME, 5);
      wb(1, `FPKC_REG_CTRL, 1);
      kp.flip(7);
      for (n = 0; n < 400 && backlight_q !== 1'b1; n++) @(posedge sys_clk);
      for (n = 0; n < 80 && backlight_q !== 1'b0; n++) @(posedge sys_clk);
      chk(n >= 40 && n <= 60, 1);
      kp.flip(7);
      repeat (250) @(posedge sys_clk);
      wb(1, `FPKC_REG_CTRL, 0);
      tap(6, 25);
      chk(screen_q, FPKC_MENU);
      c = n_commit;
      tap(6, 25);
      chk(n_commit, c + 1);
      combo();
      chk(lock_sym_q, 0);
      tap(3, 25);
      wb(1, `FPKC_REG_CTRL, 32'h8);
      combo();
      chk({lock_sym_q, screen_q}, {1'b0, FPKC_CALIB});
      tap(3, 25);
      tap(1, 25);
      chk(screen_q, FPKC_RECALL);
      tap(3, 25);
      c = n_peak;
      tap(2, 25);
      chk(n_peak, c + 1);
      standby <= 1;
      c = n_view;
      tap(7, 25);
      chk(n_view, c + 1);
      tap(7, 25);
      standby <= 0;
      c = n_close;
      s = n_shut;
      for (n = 0; n < 2; n++) begin
         adapter_only <= n[0];
         repeat (5) @(posedge sys_clk);
         auto_close_req <= 1'b1;
         auto_shutdown_req <= 1'b1;
         @(posedge sys_clk);
         auto_close_req <= 1'b0;
         auto_shutdown_req <= 1'b0;
         repeat (5) @(posedge sys_clk);
         chk(n_close - c, 1);
         chk(n_shut - s, 1);
      end
      combo();
      chk({lock_sym_q, screen_q}, {1'b1, FPKC_MEAS});
      wb(0, `FPKC_REG_STATUS, 0);
      chk(rd, 32'h202);
      c = n_lock;
      tap(0, 25);
      chk(axis_q, FPKC_AX_X);
      chk(n_lock - c, 1);
      tap(7, 25);
      chk(backlight_q, 1);
      tap(7, 25);
      combo();
      chk(lock_sym_q, 0);
      combo();
      tap(5, 50);
      chk(power_on_q, 1);
      tap(5, 90);
      chk(power_on_q, 0);
      supply_trig_sw <= 1;
      repeat (5) @(posedge sys_clk);
      supply_present <= 1;
      for (n = 0; n < 300 && screen_q !== FPKC_MEAS | splash_q !== 1'b1; n++) @(posedge sys_clk);
      chk(power_on_q, 1);
      for (n = 0; n < 11000 && splash_q !== 1'b0; n++) @(posedge sys_clk);
      tap(5, 50);
      chk(power_on_q, 1);
      supply_trig_sw <= 0;
      tap(5, 50);
      chk(power_on_q, 0);
      test_done();
   end
endmodule
